/* src/sink_audio_link_pkg.sv */
// constants for the sink audio and link configuration register bank
//
// Operation
// - lock status bit high while internal machine uses the reconfiguration port
// - audio packets accepted only while audio enable bit is one
// - info frame read as eight words, first holds header bytes zero to three
// - data bytes renumbered from zero, four per word, lowest byte low
// - audio m value in bits 23 to 0, upper bits reserved
// - audio n value in bits 23 to 0, upper bits reserved
// - info received bit set on arrival, cleared after eight reads, blocks new
// - extension received bit set on arrival, cleared after nine reads, blocks new
// - two-bit decoder error counter shown in audio status bits 2 to 1
// - every extension packet treated as exactly 32 bytes
// - extension window: nine reads, header first, ending with bytes 31 to 28
// - link rate mirror reads 0x06, 0x0A or 0x14 as configured
// - lane count mirror five bits, values one to four
// - framing mirror bit one while enhanced framing enabled
// - training pattern mirror two-bit code, 11 reserved
// - quality pattern mirror two-bit code
// - clock-out enable drives recovered clock onto test port
// - mirrors read-only, always reflect last transmitter write
package sink_audio_link_pkg;
  localparam logic [11:0] ADDR_LOCK_STATUS = 12'h02a8;
  localparam logic [11:0] ADDR_AUDIO_CONTROL = 12'h0300;
  localparam logic [11:0] ADDR_INFO_WINDOW = 12'h0304;
  localparam logic [11:0] ADDR_M_VALUE = 12'h0324;
  localparam logic [11:0] ADDR_N_VALUE = 12'h0328;
  localparam logic [11:0] ADDR_AUDIO_STATUS = 12'h032c;
  localparam logic [11:0] ADDR_EXT_WINDOW = 12'h0330;
  localparam logic [11:0] ADDR_LINK_RATE = 12'h0400;
  localparam logic [11:0] ADDR_LANE_COUNT = 12'h0404;
  localparam logic [11:0] ADDR_FRAMING = 12'h0408;
  localparam logic [11:0] ADDR_TRAINING = 12'h040c;
  localparam logic [11:0] ADDR_QUALITY = 12'h0410;
  localparam logic [11:0] ADDR_CLOCK_OUT = 12'h0414;
  localparam int INFO_WORDS = 8;
  localparam int EXT_WORDS = 9;
  localparam int EXT_BYTES = 32;
  localparam int TS_WIDTH = 24;
  localparam int BIT_AUDIO_ENABLE = 0;
  localparam int BIT_INFO_RECEIVED = 0;
  localparam int BIT_EXT_RECEIVED = 9;
  localparam int LSB_DECODER_ERRORS = 1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [7:0] RATE_1G62 = 8'h06;
  localparam logic [7:0] RATE_2G7 = 8'h0a;
  localparam logic [7:0] RATE_5G4 = 8'h14;
endpackage

/* src/sink_audio_link_regs.sv */
// axi4-lite register bank for sink audio readout and link configuration mirrors
`timescale 1ns/1ns
`default_nettype none
module sink_audio_link_regs
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // axi4-lite write address and data
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // reconfiguration port activity
  input wire logic i_reconfig_busy,
  // received audio packets
  input wire logic i_info_valid,
  input wire logic [255:0] i_info_frame,
  input wire logic i_ext_valid,
  input wire logic [287:0] i_ext_packet,
  input wire logic i_timestamp_valid,
  input wire logic [23:0] i_audio_m_value,
  input wire logic [23:0] i_audio_n_value,
  input wire logic i_decoder_error,
  // sink configuration data space writes by the transmitter
  input wire logic [7:0] i_cfg_link_rate,
  input wire logic [4:0] i_cfg_lane_count,
  input wire logic i_cfg_enhanced_framing,
  input wire logic [1:0] i_cfg_training_pattern,
  input wire logic [1:0] i_cfg_quality_pattern,
  input wire logic i_cfg_clock_out_enable,
  input wire logic i_recovered_clock,
  // block outputs
  output logic o_audio_enable,
  output logic o_info_taken,
  output logic o_ext_taken,
  output logic o_test_clock
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic lock_status;
  logic audio_enable;
  logic [255:0] info_store;
  logic [287:0] ext_store;
  logic info_received;
  logic ext_received;
  logic [3:0] info_index;
  logic [3:0] ext_index;
  logic [23:0] m_value;
  logic [23:0] n_value;
  logic [1:0] decoder_errors;
  logic [7:0] link_rate;
  logic [4:0] lane_count;
  logic framing;
  logic [1:0] training;
  logic [1:0] quality;
  logic clock_out;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic rd_fire;
  logic wr_fire;
  logic info_read;
  logic ext_read;
  logic [31:0] next_rdata;
  logic next_rresp;
  logic accept_info;
  logic accept_ext;
  logic [11:0] rd_addr;

  // low address bits are ignored so the window index moves on every unaligned alias
  assign rd_addr = {i_araddr[11:2], 2'b00};
  assign wr_fire = aw_held && w_held && !o_bvalid;
  assign rd_fire = i_arvalid && o_arready;
  assign info_read = rd_fire && rd_addr == sink_audio_link_pkg::ADDR_INFO_WINDOW;
  assign ext_read = rd_fire && rd_addr == sink_audio_link_pkg::ADDR_EXT_WINDOW;
  assign accept_info = i_info_valid && audio_enable && !info_received;
  assign accept_ext = i_ext_valid && audio_enable && !ext_received;

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= sink_audio_link_pkg::AXI_OKAY;
    end
    else
    begin
      o_awready <= !aw_held && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready <= !w_held && !(i_wvalid && o_wready) && !o_bvalid;
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {i_awaddr[11:2], 2'b00};
      end
      if (i_wvalid && o_wready)
      begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= aw_addr == sink_audio_link_pkg::ADDR_AUDIO_CONTROL ?
          sink_audio_link_pkg::AXI_OKAY : sink_audio_link_pkg::AXI_SLVERR;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      audio_enable <= 1'b0;
    else if (wr_fire && aw_addr == sink_audio_link_pkg::ADDR_AUDIO_CONTROL && w_strb[0])
      audio_enable <= w_data[sink_audio_link_pkg::BIT_AUDIO_ENABLE];
  end

  // ----------------------------------------
  // packet capture and keyhole windows
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      info_store <= '0;
      info_received <= 1'b0;
      info_index <= 4'h0;
    end
    else if (accept_info)
    begin
      info_store <= i_info_frame;
      info_received <= 1'b1;
      info_index <= 4'h0;
    end
    else if (info_read)
    begin
      if (32'(info_index) == sink_audio_link_pkg::INFO_WORDS - 1)
      begin
        info_received <= 1'b0;
        info_index <= 4'h0;
      end
      else
        info_index <= info_index + 4'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ext_store <= '0;
      ext_received <= 1'b0;
      ext_index <= 4'h0;
    end
    else if (accept_ext)
    begin
      ext_store <= i_ext_packet;
      ext_received <= 1'b1;
      ext_index <= 4'h0;
    end
    else if (ext_read)
    begin
      if (32'(ext_index) == sink_audio_link_pkg::EXT_WORDS - 1)
      begin
        ext_received <= 1'b0;
        ext_index <= 4'h0;
      end
      else
        ext_index <= ext_index + 4'h1;
    end
  end

  // ----------------------------------------
  // timestamp, error counter and status
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      m_value <= 24'h00_0000;
      n_value <= 24'h00_0000;
    end
    else if (i_timestamp_valid && audio_enable)
    begin
      m_value <= i_audio_m_value;
      n_value <= i_audio_n_value;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      decoder_errors <= 2'h0;
    else if (i_decoder_error)
      decoder_errors <= decoder_errors + 2'h1;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      lock_status <= 1'b0;
    else
      lock_status <= i_reconfig_busy;
  end

  // ----------------------------------------
  // configuration mirrors
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      link_rate <= 8'h00;
      lane_count <= 5'h00;
      framing <= 1'b0;
      training <= 2'h0;
      quality <= 2'h0;
      clock_out <= 1'b0;
    end
    else
    begin
      link_rate <= i_cfg_link_rate;
      lane_count <= i_cfg_lane_count;
      framing <= i_cfg_enhanced_framing;
      training <= i_cfg_training_pattern;
      quality <= i_cfg_quality_pattern;
      clock_out <= i_cfg_clock_out_enable;
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = 1'b0;
    case (rd_addr)
      sink_audio_link_pkg::ADDR_LOCK_STATUS: next_rdata = {31'h0, lock_status};
      sink_audio_link_pkg::ADDR_AUDIO_CONTROL: next_rdata = {31'h0, audio_enable};
      sink_audio_link_pkg::ADDR_INFO_WINDOW: next_rdata = info_store[32*info_index +: 32];
      sink_audio_link_pkg::ADDR_M_VALUE: next_rdata = {8'h00, m_value};
      sink_audio_link_pkg::ADDR_N_VALUE: next_rdata = {8'h00, n_value};
      sink_audio_link_pkg::ADDR_AUDIO_STATUS:
        next_rdata = {22'h0, ext_received, 6'h00, decoder_errors, info_received};
      sink_audio_link_pkg::ADDR_EXT_WINDOW: next_rdata = ext_store[32*ext_index +: 32];
      sink_audio_link_pkg::ADDR_LINK_RATE: next_rdata = {24'h00_0000, link_rate};
      sink_audio_link_pkg::ADDR_LANE_COUNT: next_rdata = {27'h0, lane_count};
      sink_audio_link_pkg::ADDR_FRAMING: next_rdata = {31'h0, framing};
      sink_audio_link_pkg::ADDR_TRAINING: next_rdata = {30'h0, training};
      sink_audio_link_pkg::ADDR_QUALITY: next_rdata = {30'h0, quality};
      sink_audio_link_pkg::ADDR_CLOCK_OUT: next_rdata = {31'h0, clock_out};
      default: next_rresp = 1'b1;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= sink_audio_link_pkg::AXI_OKAY;
    end
    else
    begin
      o_arready <= !o_rvalid && !rd_fire;
      if (rd_fire)
      begin
        o_rvalid <= 1'b1;
        o_rdata <= next_rdata;
        o_rresp <= next_rresp ? sink_audio_link_pkg::AXI_SLVERR : sink_audio_link_pkg::AXI_OKAY;
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_audio_enable <= 1'b0;
      o_info_taken <= 1'b0;
      o_ext_taken <= 1'b0;
      o_test_clock <= 1'b0;
    end
    else
    begin
      o_audio_enable <= audio_enable;
      o_info_taken <= accept_info;
      o_ext_taken <= accept_ext;
      o_test_clock <= clock_out & i_recovered_clock;
    end
  end

endmodule // sink_audio_link_regs
`default_nettype wire

/* test/sink_audio_link_properties.sv */
// port checks for the sink audio and link register bank
`timescale 1ns/1ns
`default_nettype none
module sink_audio_link_properties
(
  // watched ports
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] o_rresp,
  input wire logic [31:0] o_rdata,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic i_info_valid,
  input wire logic i_ext_valid,
  input wire logic o_audio_enable,
  input wire logic o_info_taken,
  input wire logic o_ext_taken,
  input wire logic i_cfg_clock_out_enable,
  input wire logic o_test_clock
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // a taken packet blocks another take of its kind for the next eight cycles
  sequence s_no_info; !o_info_taken [*8]; endsequence
  sequence s_no_ext; !o_ext_taken [*8]; endsequence
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_ranswer; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_ranswer: assert property (p_ranswer) else $error("read answer late");
  property p_err_zero; o_rvalid && o_rresp == 2'h2 |-> o_rdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_info_cause; o_info_taken |-> $past(i_info_valid) && o_audio_enable; endproperty
  a_info_cause: assert property (p_info_cause) else $error("info taken wrongly");
  property p_ext_cause; o_ext_taken |-> $past(i_ext_valid) && o_audio_enable; endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("ext taken wrongly");
  property p_info_once; o_info_taken |=> s_no_info; endproperty
  a_info_once: assert property (p_info_once) else $error("info not blocked");
  property p_ext_once; o_ext_taken |=> s_no_ext; endproperty
  a_ext_once: assert property (p_ext_once) else $error("ext not blocked");
  property p_clk_off;
    !$past(i_cfg_clock_out_enable, 1) && !$past(i_cfg_clock_out_enable, 2) |-> !o_test_clock;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("test clock while disabled");
endmodule // sink_audio_link_properties
bind sink_audio_link_regs sink_audio_link_properties i_sink_audio_link_properties (
  .i_clock, .i_rst, .o_bvalid, .i_bready, .o_bresp, .o_rvalid, .i_rready, .o_rresp,
  .o_rdata, .i_arvalid, .o_arready, .i_info_valid, .i_ext_valid, .o_audio_enable,
  .o_info_taken, .o_ext_taken, .i_cfg_clock_out_enable, .o_test_clock);
`default_nettype wire

/* test/tx_source_model.sv */
// transmitter model delivering info frames and extension packets
`timescale 1ns/1ns
`default_nettype none
module tx_source_model
(
  // clock and commands
  input wire logic i_clock,
  input wire logic i_send_info,
  input wire logic i_send_ext,
  input wire logic [31:0] i_seed,
  // packet lines
  output logic o_info_valid,
  output logic [255:0] o_info_frame,
  output logic o_ext_valid,
  output logic [287:0] o_ext_packet
);
  initial
  begin
    o_info_valid = 0;
    o_ext_valid = 0;
    o_info_frame = '0;
    o_ext_packet = '0;
  end
  // payload is valid only with its strobe, inverted otherwise
  always @(posedge i_clock)
  begin
    o_info_valid <= i_send_info;
    o_ext_valid <= i_send_ext;
    for (int k = 0; k < 8; k++)
      o_info_frame[32*k+:32] <= i_send_info ? 32'(i_seed + k) : ~o_info_frame[32*k+:32];
    for (int k = 0; k < 9; k++)
      o_ext_packet[32*k+:32] <= i_send_ext ? 32'(i_seed + k) : ~o_ext_packet[32*k+:32];
  end
endmodule // tx_source_model
`default_nettype wire

/* test/sink_audio_link_regs_test.sv */
// self-checking bench for the sink audio and link register bank
`timescale 1ns/1ns
`default_nettype none
module sink_audio_link_regs_test;
  logic i_clock = 0, i_rst = 1;
  logic [11:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, seed = 32'h0000_32ef, tx_seed = 0, d;
  logic [3:0] i_wstrb = 0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic i_reconfig_busy = 0, i_timestamp_valid = 0, i_decoder_error = 0;
  logic [23:0] i_audio_m_value = 0, i_audio_n_value = 0;
  logic [7:0] i_cfg_link_rate = 0;
  logic [4:0] i_cfg_lane_count = 0;
  logic [1:0] i_cfg_training_pattern = 0, i_cfg_quality_pattern = 0, r;
  logic i_cfg_enhanced_framing = 0, i_cfg_clock_out_enable = 0, i_recovered_clock = 0;
  logic send_info = 0, send_ext = 0;
  wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_info_valid, i_ext_valid;
  wire logic [1:0] o_bresp, o_rresp;
  wire logic [31:0] o_rdata;
  wire logic [255:0] i_info_frame;
  wire logic [287:0] i_ext_packet;
  wire logic o_audio_enable, o_info_taken, o_ext_taken, o_test_clock;
  int err_count = 0, comparisons = 0, cyc = 0, info_takes = 0, ext_takes = 0;
  sink_audio_link_regs i_sink_audio_link_regs (.i_clock, .i_rst, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
    .i_reconfig_busy, .i_info_valid, .i_info_frame, .i_ext_valid, .i_ext_packet,
    .i_timestamp_valid, .i_audio_m_value, .i_audio_n_value, .i_decoder_error,
    .i_cfg_link_rate, .i_cfg_lane_count, .i_cfg_enhanced_framing, .i_cfg_training_pattern,
    .i_cfg_quality_pattern, .i_cfg_clock_out_enable, .i_recovered_clock, .o_audio_enable,
    .o_info_taken, .o_ext_taken, .o_test_clock);
  tx_source_model i_tx_source_model (.i_clock, .i_send_info(send_info), .i_send_ext(send_ext),
    .i_seed(tx_seed), .o_info_valid(i_info_valid), .o_info_frame(i_info_frame),
    .o_ext_valid(i_ext_valid), .o_ext_packet(i_ext_packet));
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cyc++;
    info_takes += int'(o_info_taken);
    ext_takes += int'(o_ext_taken);
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [31:0] st(input logic ext, input logic [1:0] cnt, input logic inf);
    return {22'h0, ext, 6'h0, cnt, inf};
  endfunction
  function automatic logic [7:0] rate(input int i);
    if (i % 3 == 0) return sink_audio_link_pkg::RATE_1G62;
    if (i % 3 == 1) return sink_audio_link_pkg::RATE_2G7;
    return sink_audio_link_pkg::RATE_5G4;
  endfunction
  task end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= v;
    i_wstrb <= 4'hf;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do
    begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end
    while (o_bvalid !== 1'b1);
    i_bready <= 0;
    r = o_bresp;
  endtask
  task rd(input logic [11:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do
    begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 0;
    end
    while (o_rvalid !== 1'b1);
    i_rready <= 0;
    d = o_rdata;
    r = o_rresp;
  endtask
  task rc(input string n, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(n, d, e);
    chk(n, 32'(r), 32'(sink_audio_link_pkg::AXI_OKAY));
  endtask
  task pkt(input logic ext, input logic [31:0] s);
    @(posedge i_clock);
    tx_seed <= s;
    send_info <= !ext;
    send_ext <= ext;
    @(posedge i_clock);
    send_info <= 0;
    send_ext <= 0;
    repeat (3) @(posedge i_clock);
  endtask
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_rst <= 0;
    i_reconfig_busy <= 1;
    repeat (3) @(posedge i_clock);
    rc("lock", sink_audio_link_pkg::ADDR_LOCK_STATUS, 32'h0000_0001);
    i_reconfig_busy <= 0;
    do rd(sink_audio_link_pkg::ADDR_LOCK_STATUS); while (d !== 32'h0000_0000);
    rc("lock", sink_audio_link_pkg::ADDR_LOCK_STATUS, 32'h0000_0000);
    wr(sink_audio_link_pkg::ADDR_AUDIO_CONTROL, 32'hffff_fffe);
    rc("control", sink_audio_link_pkg::ADDR_AUDIO_CONTROL, 32'h0000_0000);
    pkt(0, 32'h0000_1111);
    pkt(1, 32'h0000_2222);
    rc("status", sink_audio_link_pkg::ADDR_AUDIO_STATUS, st(0, 0, 0));
    wr(sink_audio_link_pkg::ADDR_AUDIO_CONTROL, 32'h0000_0001);
    rc("control", sink_audio_link_pkg::ADDR_AUDIO_CONTROL, 32'h0000_0001);
    chk("enable out", 32'(o_audio_enable), 32'h0000_0001);
    wr(sink_audio_link_pkg::ADDR_LINK_RATE, 32'h0000_00ff);
    chk("ro write", 32'(r), 32'(sink_audio_link_pkg::AXI_SLVERR));
    rd(12'h0500);
    chk("unmapped", 32'(r), 32'(sink_audio_link_pkg::AXI_SLVERR));
    repeat (10) @(posedge i_clock) i_decoder_error <= ~i_decoder_error;
    rc("status", sink_audio_link_pkg::ADDR_AUDIO_STATUS, st(0, 1, 0));
    seed = xs(seed);
    @(posedge i_clock);
    i_audio_m_value <= seed[23:0];
    i_audio_n_value <= seed[31:8];
    i_timestamp_valid <= 1;
    @(posedge i_clock);
    i_timestamp_valid <= 0;
    rc("m", sink_audio_link_pkg::ADDR_M_VALUE, {8'h00, seed[23:0]});
    rc("n", sink_audio_link_pkg::ADDR_N_VALUE, {8'h00, seed[31:8]});
    seed = xs(seed);
    pkt(0, seed);
    rc("status", sink_audio_link_pkg::ADDR_AUDIO_STATUS, st(0, 1, 1));
    pkt(0, ~seed);
    for (int k = 0; k < 8; k++) rc("info", sink_audio_link_pkg::ADDR_INFO_WINDOW, seed + k);
    rc("status", sink_audio_link_pkg::ADDR_AUDIO_STATUS, st(0, 1, 0));
    seed = xs(seed);
    pkt(1, seed);
    rc("status", sink_audio_link_pkg::ADDR_AUDIO_STATUS, st(1, 1, 0));
    pkt(1, ~seed);
    for (int k = 0; k < 9; k++) rc("ext", sink_audio_link_pkg::ADDR_EXT_WINDOW, seed + k);
    rc("status", sink_audio_link_pkg::ADDR_AUDIO_STATUS, st(0, 1, 0));
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_clock);
      i_cfg_link_rate <= rate(i);
      i_cfg_lane_count <= 5'(i + 1);
      i_cfg_enhanced_framing <= i[0];
      i_cfg_training_pattern <= 2'(i % 3);
      i_cfg_quality_pattern <= 2'(i);
      i_cfg_clock_out_enable <= i[0];
      i_recovered_clock <= i[1];
      repeat (3) @(posedge i_clock);
      rc("rate", sink_audio_link_pkg::ADDR_LINK_RATE, 32'(rate(i)));
      rc("lanes", sink_audio_link_pkg::ADDR_LANE_COUNT, 32'(i + 1));
      rc("framing", sink_audio_link_pkg::ADDR_FRAMING, 32'(i[0]));
      rc("training", sink_audio_link_pkg::ADDR_TRAINING, 32'(i % 3));
      rc("quality", sink_audio_link_pkg::ADDR_QUALITY, 32'(i));
      rc("clock out", sink_audio_link_pkg::ADDR_CLOCK_OUT, 32'(i[0]));
      chk("test clock", 32'(o_test_clock), 32'(i[0] & i[1]));
    end
    chk("info takes", 32'(info_takes), 32'h0000_0001);
    chk("ext takes", 32'(ext_takes), 32'h0000_0001);
    end_sim();
  end
endmodule // sink_audio_link_regs_test
`default_nettype wire
